// File: logic/aioc_pkg.sv
// Package for the accessory I/O command interpreter
package aioc_pkg;
  localparam int unsigned PORT_W = 16;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned MODE_W = 5;
  localparam logic [3:0] CMD_SEL_RES_SET   = 4'h0;
  localparam logic [3:0] CMD_SEL_RES_QRY   = 4'h1;
  localparam logic [3:0] CMD_SLOT_ASSIGN   = 4'h2;
  localparam logic [3:0] CMD_SLOT_QRY      = 4'h3;
  localparam logic [3:0] CMD_SELF_TEST_QRY = 4'h4;
  localparam logic [3:0] CMD_PATH_SET      = 4'h5;
  localparam logic [3:0] CMD_PATH_QRY      = 4'h6;
  localparam logic [3:0] CMD_VERIFY_SET    = 4'h7;
  localparam logic [3:0] CMD_EXP_RES_SET   = 4'h8;
  localparam logic [3:0] CMD_EXP_RES_QRY   = 4'h9;
  localparam logic [3:0] CMD_DIR_SET       = 4'hA;
  localparam logic [3:0] CMD_MODE_SELECT   = 4'hB;
  localparam logic [3:0] CMD_MODE_QRY      = 4'hC;
  localparam logic [4:0] MODE_GENERAL  = 5'h00;
  localparam logic [4:0] MODE_SELECTOR = 5'h02;
  localparam logic [4:0] MODE_EXPANDER = 5'h08;
  localparam logic [4:0] MODE_RST      = 5'h00;
  localparam logic [3:0] SLOT_MAX      = 4'hA;
  localparam logic [1:0] CODE_MAX      = 2'h2;
  localparam logic [15:0] DIR_RST      = 16'h0000;
  localparam logic [15:0] LEVEL_RST    = 16'hFFFF;
  localparam logic [15:0] SELF_TEST_PASS = 16'h0000;
  typedef struct packed {
    logic [3:0]  op;
    logic [15:0] arg0;
    logic [15:0] arg1;
    logic [15:0] arg2;
    logic        flag_given;
    logic [15:0] flag;
  } aioc_cmd_t;
  typedef struct packed {
    logic [15:0] val0;
    logic [15:0] val1;
    logic [15:0] val2;
  } aioc_resp_t;
endpackage

// File: logic/aioc_top.sv
// Accessory I/O command interpreter
//
// Overview of operation
// - Selector resistor set 1/0, selector mode only
// - Selector resistor query returns stored state
// - Store three expander slots 0 to 10
// - Slot assign needs expander mode, safe, off
// - Slot query returns voltage, current, high-voltage
// - Self-test after assignment, zero means pass
// - Expander path 0 open, 1, 2
// - Path set needs expander mode, no high voltage
// - Path query returns stored code
// - Verify mode 0 normal, 1, 2
// - Verify/resistor need expander mode, open, off
// - Expander resistor 0 disable, 1 enable
// - Expander resistor query returns stored state
// - Direction mask bits: 0 output, 1 input
// - Direction set only in general mode
// - Reset or clear: all outputs, high level
// - Changed direction path goes to high level
// - Trigger paths keep direction unchanged
// - Mode codes 0,1,2,4,8,16 accepted
// - Optional flag disables or enables mode
// - Nonzero modes combine, order independent; code 0 with flag on clears all
// - Mode query returns sum of enabled codes
`timescale 1ns/10ps
module aioc_top (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              dev_clear,
  // Command
  input  wire logic              cmd_valid,
  input  wire aioc_pkg::aioc_cmd_t cmd,
  // Environment status, same clock domain
  input  wire logic              high_voltage_active,
  input  wire logic              channels_off,
  input  wire logic [15:0]       trigger_mask,
  // Answer
  output logic                   done,
  output logic                   error,
  output aioc_pkg::aioc_resp_t   resp,
  // Port and accessory state
  output logic [15:0]            port_dir,
  output logic [15:0]            port_level,
  output logic [4:0]             mode_set,
  output logic                   selector_resistor,
  output logic [3:0]             slot_vctl,
  output logic [3:0]             slot_ictl,
  output logic [3:0]             slot_hv,
  output logic [1:0]             exp_path,
  output logic [1:0]             exp_verify,
  output logic                   exp_resistor,
  output logic                   self_test_run
);
  import aioc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  logic        ok;
  logic        bad;
  logic        sel_mode;
  logic        exp_mode;
  logic        gen_mode;
  logic        mode_code_ok;
  logic [4:0]  mode_bit;
  logic        assigned_q;
  logic [15:0] new_dir;
  logic        flag_on;
  logic        take;

  // General mode means no accessory mode enabled
  assign gen_mode = (mode_set == MODE_GENERAL);
  assign sel_mode = |(mode_set & MODE_SELECTOR);
  assign exp_mode = |(mode_set & MODE_EXPANDER);
  // Trigger paths keep their current direction
  assign new_dir  = (cmd.arg0 & ~trigger_mask) | (port_dir & trigger_mask);
  assign flag_on  = !cmd.flag_given || (cmd.flag == 16'h0001);
  // One shared strobe gates every setting except mode and selector resistor, which spell out cmd_valid && ok
  assign take     = cmd_valid && ok;

  // Only zero and single-bit codes up to 16 name a mode
  always_comb begin
    mode_code_ok = 1'b1;
    mode_bit     = 5'h00;
    case (cmd.arg0)
      16'h0000: mode_bit = 5'h00;
      16'h0001: mode_bit = 5'h01;
      16'h0002: mode_bit = 5'h02;
      16'h0004: mode_bit = 5'h04;
      16'h0008: mode_bit = 5'h08;
      16'h0010: mode_bit = 5'h10;
      default:  mode_code_ok = 1'b0;
    endcase
  end

  // Acceptance: precondition and range checks decide everything below
  // Unlisted op codes fall to the default and are refused
  always_comb begin
    ok  = 1'b0;
    bad = 1'b0;
    case (cmd.op)
      CMD_SEL_RES_SET: begin
        ok = sel_mode && cmd.arg0 <= 16'h0001;
      end
      CMD_SLOT_ASSIGN: begin
        ok = exp_mode && !high_voltage_active && channels_off
             && cmd.arg0 <= 16'(SLOT_MAX) && cmd.arg1 <= 16'(SLOT_MAX)
             && cmd.arg2 <= 16'(SLOT_MAX);
      end
      CMD_SELF_TEST_QRY: begin
        ok = assigned_q;
      end
      CMD_PATH_SET: begin
        ok = exp_mode && !high_voltage_active && cmd.arg0 <= 16'(CODE_MAX);
      end
      CMD_VERIFY_SET: begin
        ok = exp_mode && exp_path == 2'h0 && channels_off
             && cmd.arg0 <= 16'(CODE_MAX);
      end
      CMD_EXP_RES_SET: begin
        ok = exp_mode && exp_path == 2'h0 && channels_off
             && cmd.arg0 <= 16'h0001;
      end
      CMD_DIR_SET: begin
        ok = gen_mode;
      end
      CMD_MODE_SELECT: begin
        ok = mode_code_ok && (!cmd.flag_given || cmd.flag <= 16'h0001);
      end
      CMD_SEL_RES_QRY, CMD_SLOT_QRY, CMD_PATH_QRY, CMD_EXP_RES_QRY, CMD_MODE_QRY: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    bad = !ok;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Answer handshake; every command, taken or not, gets exactly one done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= cmd_valid;
    end
  end

  // Refusal flag rides with done for one cycle only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error <= 1'b0;
    end else begin
      error <= cmd_valid && bad;
    end
  end

  // Taken settings answer zero; refusals leave the last answer standing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp <= '0;
    end else if (cmd_valid && ok) begin
      resp <= '0;
      case (cmd.op)
        CMD_SEL_RES_QRY:   resp.val0 <= {15'h0000, selector_resistor};
        CMD_SLOT_QRY: begin
          resp.val0 <= {12'h000, slot_vctl};
          resp.val1 <= {12'h000, slot_ictl};
          resp.val2 <= {12'h000, slot_hv};
        end
        CMD_SELF_TEST_QRY: resp.val0 <= SELF_TEST_PASS;
        CMD_PATH_QRY:      resp.val0 <= {14'h0000, exp_path};
        CMD_EXP_RES_QRY:   resp.val0 <= {15'h0000, exp_resistor};
        CMD_MODE_QRY:      resp.val0 <= {11'h000, mode_set};
        default:           resp <= '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control mode set; each nonzero code is its own bit, so their order never matters, but code 0 with the flag on clears all
  // Code 0 with the flag off is taken but changes nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_set <= MODE_RST;
    end else if (dev_clear) begin
      mode_set <= MODE_RST;
    end else if (cmd_valid && ok && cmd.op == CMD_MODE_SELECT) begin
      if (mode_bit == 5'h00) begin
        mode_set <= flag_on ? MODE_GENERAL : mode_set;
      end else if (flag_on) begin
        mode_set <= mode_set | mode_bit;
      end else begin
        mode_set <= mode_set & ~mode_bit;
      end
    end
  end

  // Port direction; trigger paths are already folded into new_dir
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_dir <= DIR_RST;
    end else if (dev_clear) begin
      port_dir <= DIR_RST;
    end else if (take && cmd.op == CMD_DIR_SET) begin
      port_dir <= new_dir;
    end
  end

  // Port levels; only raised here, and reset or clear set them all high again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_level <= LEVEL_RST;
    end else if (dev_clear) begin
      port_level <= LEVEL_RST;
    end else if (take && cmd.op == CMD_DIR_SET) begin
      port_level <= port_level | (new_dir ^ port_dir);
    end
  end

  // Selector series resistor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selector_resistor <= 1'b0;
    end else if (dev_clear) begin
      selector_resistor <= 1'b0;
    end else if (cmd_valid && ok && cmd.op == CMD_SEL_RES_SET) begin
      selector_resistor <= cmd.arg0[0];
    end
  end

  // Expander slot assignment; range already checked, so the cut is safe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_vctl <= 4'h0;
      slot_ictl <= 4'h0;
      slot_hv   <= 4'h0;
    end else if (dev_clear) begin
      slot_vctl <= 4'h0;
      slot_ictl <= 4'h0;
      slot_hv   <= 4'h0;
    end else if (take && cmd.op == CMD_SLOT_ASSIGN) begin
      slot_vctl <= cmd.arg0[3:0];
      slot_ictl <= cmd.arg1[3:0];
      slot_hv   <= cmd.arg2[3:0];
    end
  end

  // Self-test gate; any taken assignment opens it, even all zeros
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      assigned_q <= 1'b0;
    end else if (dev_clear) begin
      assigned_q <= 1'b0;
    end else if (take && cmd.op == CMD_SLOT_ASSIGN) begin
      assigned_q <= 1'b1;
    end
  end

  // Expander path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_path <= 2'h0;
    end else if (dev_clear) begin
      exp_path <= 2'h0;
    end else if (take && cmd.op == CMD_PATH_SET) begin
      exp_path <= cmd.arg0[1:0];
    end
  end

  // Expander verify mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_verify <= 2'h0;
    end else if (dev_clear) begin
      exp_verify <= 2'h0;
    end else if (take && cmd.op == CMD_VERIFY_SET) begin
      exp_verify <= cmd.arg0[1:0];
    end
  end

  // Expander series resistor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_resistor <= 1'b0;
    end else if (dev_clear) begin
      exp_resistor <= 1'b0;
    end else if (take && cmd.op == CMD_EXP_RES_SET) begin
      exp_resistor <= cmd.arg0[0];
    end
  end

  // Self-test strobe; the result itself is a fixed pass here
  // No test engine sits behind it, so a failure is never reported
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      self_test_run <= 1'b0;
    end else begin
      self_test_run <= cmd_valid && ok && cmd.op == CMD_SELF_TEST_QRY;
    end
  end
endmodule

// File: tb/aioc_host.sv
// Host program model issuing one command per call
`timescale 1ns/10ps
module aioc_host (
  // Clock
  input  wire logic           clk,
  // Command out
  output aioc_pkg::aioc_cmd_t cmd,
  output logic                cmd_valid
);
  import aioc_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  ////////////////////////////////////////////////////////////////
  // Caller picks preconditions, so refusals can be provoked
  task automatic issue(input aioc_cmd_t c);
    cmd_valid = 1'b1;
    cmd = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    // Released bus shows no stale value
    cmd = ~c;
  endtask
endmodule

// File: tb/aioc_properties.sv
// Port checks for the accessory command interpreter
`timescale 1ns/10ps
module aioc_properties (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 dev_clear,
  // Command
  input wire logic                 cmd_valid,
  input wire aioc_pkg::aioc_cmd_t  cmd,
  input wire logic [15:0]          trigger_mask,
  // Answer and state
  input wire logic                 done,
  input wire logic                 error,
  input wire aioc_pkg::aioc_resp_t resp,
  input wire logic [15:0]          port_dir,
  input wire logic [15:0]          port_level,
  input wire logic [4:0]           mode_set,
  input wire logic                 selector_resistor,
  input wire logic [1:0]           exp_path,
  input wire logic                 self_test_run
);
  import aioc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic go;
  // Clear beats commands, so those cycles are left out
  assign go = cmd_valid && !dev_clear;
  ////////////////////////////////////////////////////////////////
  property p_answer; go |=> done; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_bad_op; go && cmd.op > CMD_MODE_QRY |=> error; endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad op taken");
  property p_sel_gate;
    go && cmd.op == CMD_SEL_RES_SET && !mode_set[1] |=> error && $stable(selector_resistor);
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("selector set ungated");
  property p_dir_ok;
    go && cmd.op == CMD_DIR_SET && mode_set == MODE_GENERAL |=> !error && port_dir ==
      (($past(cmd.arg0) & ~$past(trigger_mask)) | ($past(port_dir) & $past(trigger_mask)));
  endproperty
  a_dir_ok: assert property (p_dir_ok) else $error("direction wrong");
  property p_lvl;
    !$stable(port_dir) |-> ((port_dir ^ $past(port_dir)) & ~port_level) == 16'h0000;
  endproperty
  a_lvl: assert property (p_lvl) else $error("changed path not high");
  property p_path_rng;
    go && cmd.op == CMD_PATH_SET && cmd.arg0 > 16'h0002 |=> error && $stable(exp_path);
  endproperty
  a_path_rng: assert property (p_path_rng) else $error("path range");
  property p_self; self_test_run |-> done && !error && resp.val0 == SELF_TEST_PASS; endproperty
  a_self: assert property (p_self) else $error("self-test result");
  property p_mode_sum;
    go && cmd.op == CMD_MODE_QRY |=> resp.val0 == {11'h000, $past(mode_set)};
  endproperty
  a_mode_sum: assert property (p_mode_sum) else $error("mode sum");
  c_dir: cover property (go && cmd.op == CMD_DIR_SET && mode_set == MODE_GENERAL);
  c_self: cover property (self_test_run);
  c_sum: cover property (done && resp.val0 == 16'h001C);
endmodule
bind aioc_top aioc_properties u_props (.clk(clk), .rst(rst), .dev_clear(dev_clear),
  .cmd_valid(cmd_valid), .cmd(cmd), .trigger_mask(trigger_mask), .done(done),
  .error(error), .resp(resp), .port_dir(port_dir), .port_level(port_level),
  .mode_set(mode_set), .selector_resistor(selector_resistor), .exp_path(exp_path),
  .self_test_run(self_test_run));

// File: tb/tb_aioc_top.sv
// Self-checking bench for the accessory command interpreter
`timescale 1ns/10ps
module tb_aioc_top;
  import aioc_pkg::*;
  localparam logic [15:0] CODES [7] = '{16'h0, 16'h1, 16'h2, 16'h4, 16'h8, 16'h10, 16'h5};
  localparam logic [15:0] ORD [4] = '{16'h0, 16'h10, 16'h4, 16'h8};
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         dev_clear = 1'b0;
  logic         hv = 1'b0;
  logic         off = 1'b0;
  logic [15:0]  trig = 16'h0000;
  logic         cmd_valid, done, error, stest, sr, res, m_sr, m_res, m_asg;
  aioc_cmd_t    cmd, c;
  aioc_resp_t   resp, m_rsp;
  logic [15:0]  dir, lvl, m_dir, m_lvl;
  logic [4:0]   mode, m_mode;
  logic [3:0]   sv, si, sh, m_v, m_i, m_h;
  logic [1:0]   pth, ver, m_path, m_ver;
  logic [104:0] qe [$];
  logic [104:0] seen;
  int           fails = 0;
  int           tests_run = 0;
  always #5 clk = ~clk;
  aioc_host host (.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid));
  aioc_top dut (.clk(clk), .rst(rst), .dev_clear(dev_clear), .cmd_valid(cmd_valid),
    .cmd(cmd), .high_voltage_active(hv), .channels_off(off), .trigger_mask(trig),
    .done(done), .error(error), .resp(resp), .port_dir(dir), .port_level(lvl),
    .mode_set(mode), .selector_resistor(sr), .slot_vctl(sv), .slot_ictl(si),
    .slot_hv(sh), .exp_path(pth), .exp_verify(ver), .exp_resistor(res),
    .self_test_run(stest));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [104:0] s, input logic [104:0] x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic clr();
    {m_dir, m_lvl, m_mode, m_sr, m_v, m_i, m_h, m_path, m_ver, m_res, m_asg} =
      {DIR_RST, LEVEL_RST, 24'h000000};
  endtask
  // Reference model; expectation queued before the command goes out
  task automatic send(input aioc_cmd_t c);
    logic        ok, x;
    logic [15:0] a;
    @(negedge clk);
    hv = $urandom_range(0, 3) == 0;
    off = $urandom_range(0, 3) != 0;
    trig = 16'($urandom & $urandom);
    a = c.arg0;
    x = m_mode[3] && !hv;
    ok = 1'b1;
    case (c.op)
      CMD_SEL_RES_SET: begin
        ok = m_mode[1] && a <= 16'h1;
        if (ok) m_sr = a[0];
      end
      CMD_SEL_RES_QRY: m_rsp = {16'(m_sr), 32'h0};
      CMD_SLOT_ASSIGN: begin
        ok = x && off && a <= SLOT_MAX && c.arg1 <= SLOT_MAX && c.arg2 <= SLOT_MAX;
        if (ok) {m_v, m_i, m_h, m_asg} = {a[3:0], c.arg1[3:0], c.arg2[3:0], 1'b1};
      end
      CMD_SLOT_QRY: m_rsp = {12'h0, m_v, 12'h0, m_i, 12'h0, m_h};
      CMD_SELF_TEST_QRY: begin
        ok = m_asg;
        if (ok) m_rsp = {SELF_TEST_PASS, 32'h0};
      end
      CMD_PATH_SET: begin
        ok = x && a <= 16'(CODE_MAX);
        if (ok) m_path = a[1:0];
      end
      CMD_PATH_QRY: m_rsp = {14'h0, m_path, 32'h0};
      CMD_VERIFY_SET, CMD_EXP_RES_SET: begin
        ok = m_mode[3] && m_path == 2'h0 && off &&
          a <= (c.op == CMD_VERIFY_SET ? 16'(CODE_MAX) : 16'h1);
        if (ok && c.op == CMD_VERIFY_SET) m_ver = a[1:0];
        else if (ok) m_res = a[0];
      end
      CMD_EXP_RES_QRY: m_rsp = {16'(m_res), 32'h0};
      CMD_DIR_SET: begin
        ok = m_mode == MODE_GENERAL;
        a = (a & ~trig) | (m_dir & trig);
        if (ok) {m_lvl, m_dir} = {m_lvl | (m_dir ^ a), a};
      end
      CMD_MODE_SELECT: begin
        ok = a < 16'h20 && $countones(a) < 2 && !(c.flag_given && c.flag > 16'h1);
        x = !c.flag_given || c.flag[0];
        if (ok && a == 16'h0 && x) m_mode = MODE_RST;
        else if (ok && a != 16'h0) m_mode = x ? m_mode | a[4:0] : m_mode & ~a[4:0];
      end
      CMD_MODE_QRY: m_rsp = {11'h0, m_mode, 32'h0};
      default: ok = 1'b0;
    endcase
    // Taken settings answer zero; refusals leave the last answer
    if (ok && !(c.op inside {CMD_SEL_RES_QRY, CMD_SLOT_QRY, CMD_SELF_TEST_QRY, CMD_PATH_QRY,
        CMD_EXP_RES_QRY, CMD_MODE_QRY})) m_rsp = '0;
    x = ok && c.op == CMD_SELF_TEST_QRY;
    qe.push_back({!ok, x, m_rsp, m_dir, m_lvl, m_mode, m_sr, m_v, m_i, m_h, m_path, m_ver,
      m_res});
    host.issue(c);
  endtask
  task automatic clear();
    @(negedge clk);
    dev_clear = 1'b1;
    @(negedge clk);
    dev_clear = 1'b0;
    clr();
    chk(105'({dir, lvl}), 105'({DIR_RST, LEVEL_RST}));
    send({CMD_MODE_QRY, 65'h0});
  endtask
  // Result read in the cycle it stands
  always @(negedge clk) begin
    if (done === 1'b1) begin
      seen = {error, stest, resp, dir, lvl, mode, sr, sv, si, sh, pth, ver, res};
      if (qe.size() == 0) chk(105'h1, 105'h0);
      else chk(seen, qe.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hEBA275BD));
    m_rsp = '0;
    clr();
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    foreach (CODES[k]) send({CMD_MODE_SELECT, CODES[k], 32'h0, 1'b1, 16'h1});
    foreach (ORD[k]) send({CMD_MODE_SELECT, ORD[k], 49'h0});
    send({CMD_MODE_QRY, 65'h0});
    for (int n = 0; n < 1500; n++) begin
      c = {4'($urandom), 16'($urandom_range(0, 11)), 16'($urandom_range(0, 11)),
        16'($urandom_range(0, 11)), 1'($urandom), 16'($urandom_range(0, 2))};
      if (c.op == CMD_MODE_SELECT) c.arg0 = CODES[$urandom_range(0, 6)];
      if (c.op == CMD_DIR_SET) c.arg0 = 16'($urandom);
      if (n % 211 == 0) clear();
      send(c);
    end
    repeat (3) @(negedge clk);
    chk(105'(qe.size()), 105'h0);
    give_verdict();
  end
endmodule
